/* File: include/isa_pkg.sv */
// Shared constants, state encoding and decode helpers for the subaddress access slave
package isa_pkg;

	// Upper five address bits; the two select pins supply the low two bits
	localparam logic [4:0] ISA_ADDR_PREFIX = 5'h0D;
	// Broadcast address
	localparam logic [6:0] ISA_GEN_CALL = 7'h00;
	// Bit count reached after a whole byte has been clocked
	localparam logic [3:0] ISA_BIT_LAST = 4'h8;
	// Largest data set held for one write subaddress
	localparam int ISA_MAX_BYTES = 32;
	localparam logic [3:0] ISA_WORDS_MAX = 4'h8;
	localparam logic [3:0] ISA_WORDS_MIN = 4'h1;
	// Reset values, and the index of the last byte in a word
	localparam logic [7:0] ISA_SUBADDR_RST = 8'h00;
	localparam logic [5:0] ISA_BCNT_RST = 6'h00;
	localparam logic [1:0] ISA_LAST_BYTE = 2'h3;
	// Pin sampler lanes
	localparam int ISA_SYNC_W = 4;
	localparam int ISA_PIN_SCL = 0;
	localparam int ISA_PIN_SDA = 1;
	localparam int ISA_PIN_SEL_LO = 2;
	localparam int ISA_PIN_SEL_HI = 3;

	// Nine states need four bits
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_WR,
		ST_WACK,
		ST_FETCH,
		ST_LOAD,
		ST_RD,
		ST_RACK
	} isa_state_e;

	// Words per set, kept inside 1..8 so the set buffer cannot overflow
	function automatic logic [3:0] isa_words(input logic [3:0] w);
		if (w < ISA_WORDS_MIN) begin
			return ISA_WORDS_MIN;
		end else if (w > ISA_WORDS_MAX) begin
			return ISA_WORDS_MAX;
		end
		return w;
	endfunction

	// Mask of implemented bits; 0 or 32 and above means a full word
	function automatic logic [31:0] isa_mask(input logic [5:0] bits);
		if (bits == 6'h00 || bits >= 6'h20) begin
			return 32'hFFFFFFFF;
		end
		return ~(32'hFFFFFFFF << bits);
	endfunction

endpackage

/* File: hw/isa_line_sampler.sv */
// Pin synchroniser and bus condition detector for the subaddress access slave
`timescale 1ns/1ns
module isa_line_sampler
	import isa_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [ISA_SYNC_W-1:0] i_pins,
	output logic [ISA_SYNC_W-1:0] o_levels,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_start,
	output logic o_stop
);

	typedef struct packed {
		logic [ISA_SYNC_W-1:0] meta;
		logic [ISA_SYNC_W-1:0] sync;
		logic [ISA_SYNC_W-1:0] prev;
	} isa_smp_s;

	isa_smp_s r;
	isa_smp_s n;

	logic scl_now;
	logic sda_now;
	logic scl_old;
	logic sda_old;

	// Two stages, then one history stage for edge detection
	always_comb begin
		n = r;
		n.meta = i_pins;
		n.sync = r.meta;
		n.prev = r.sync;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '1;
		end else begin
			r <= n;
		end
	end

	// Only the second and history stages feed the detectors
	assign scl_now = r.sync[ISA_PIN_SCL];
	assign sda_now = r.sync[ISA_PIN_SDA];
	assign scl_old = r.prev[ISA_PIN_SCL];
	assign sda_old = r.prev[ISA_PIN_SDA];
	assign o_levels = r.sync;
	assign o_scl_rise = !scl_old && scl_now;
	assign o_scl_fall = scl_old && !scl_now;
	// SDA edges while SCL stays high are bus conditions
	assign o_start = scl_old && scl_now && sda_old && !sda_now;
	assign o_stop = scl_old && scl_now && !sda_old && sda_now;

endmodule

/* File: hw/isa_slave.sv */
// Bus slave giving an outside host access to the subaddressed parameter space
`timescale 1ns/1ns
module isa_slave
	import isa_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	output logic o_scl_o,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	input wire logic i_addr_select_low_pin,
	input wire logic i_addr_select_high_pin,
	input wire logic i_master_mode,
	output logic o_slave_en,
	output logic [7:0] o_cur_subaddr,
	input wire logic [3:0] i_set_words,
	output logic o_wr_valid,
	output logic [7:0] o_wr_subaddr,
	output logic [2:0] o_wr_word_idx,
	output logic [31:0] o_wr_data,
	output logic o_rd_req,
	output logic [2:0] o_rd_word_idx,
	input wire logic i_rd_ack,
	input wire logic [31:0] i_rd_data,
	input wire logic [5:0] i_rd_bits
);

	typedef struct packed {
		isa_state_e st;
		logic [3:0] bitc;
		logic [7:0] sr;
		logic rw;
		logic first;
		logic hack;
		logic [7:0] sa;
		logic [5:0] bcnt;
		logic [ISA_MAX_BYTES-1:0][7:0] buff;
		logic [1:0] rbyte;
		logic [2:0] rword;
		logic [31:0] rdw;
		logic cm_busy;
		logic [2:0] cm_idx;
		logic [2:0] cm_last;
		logic [7:0] cm_sa;
		logic lo;
		logic sda_oe;
		logic scl_oe;
		logic slave_en;
		logic wr_valid;
		logic [7:0] wr_sa;
		logic [2:0] wr_idx;
		logic [31:0] wr_data;
		logic rd_req;
	} isa_state_s;

	isa_state_s r;
	isa_state_s n;

	logic [ISA_SYNC_W-1:0] lv;
	logic [ISA_SYNC_W-1:0] pins;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_in;
	logic [3:0] setw;
	logic [5:0] setb;
	logic [31:0] word_sel;
	logic [7:0] byte_sel;

	// Pin lanes packed for the sampler
	assign pins[ISA_PIN_SCL] = i_scl;
	assign pins[ISA_PIN_SDA] = i_sda;
	assign pins[ISA_PIN_SEL_LO] = i_addr_select_low_pin;
	assign pins[ISA_PIN_SEL_HI] = i_addr_select_high_pin;

	isa_line_sampler u_smp (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_pins(pins),
		.o_levels(lv),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(bus_start),
		.o_stop(bus_stop)
	);

	// Own address, select pins in the low bits, or the broadcast write
	function automatic logic addr_hit(input logic [7:0] a, input logic hi, input logic lo);
		return (a[7:1] == {ISA_ADDR_PREFIX, hi, lo}) || (a[7:1] == ISA_GEN_CALL && !a[0]);
	endfunction

	// Byte of a word in transmit order, high byte first
	function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] k);
		unique case (k)
			2'h0: return w[31:24];
			2'h1: return w[23:16];
			2'h2: return w[15:8];
			2'h3: return w[7:0];
		endcase
	endfunction

	// Set geometry follows the subaddress currently on o_cur_subaddr
	assign sda_in = lv[ISA_PIN_SDA];
	assign setw = isa_words(i_set_words);
	assign setb = {setw, 2'b00};
	// Short subaddresses read as zero above their width
	assign word_sel = (r.rbyte == 2'h0) ? (i_rd_data & isa_mask(i_rd_bits)) : r.rdw;
	assign byte_sel = pick(word_sel, r.rbyte);

	always_comb begin
		n = r;
		n.wr_valid = 1'b0;
		n.rd_req = 1'b0;
		n.lo = 1'b0;
		// Complete sets stream out one word per cycle, far faster than the next byte
		if (r.cm_busy) begin
			n.wr_valid = 1'b1;
			n.wr_sa = r.cm_sa;
			n.wr_idx = r.cm_idx;
			n.wr_data = {r.buff[{r.cm_idx, 2'b00}], r.buff[{r.cm_idx, 2'b01}],
				r.buff[{r.cm_idx, 2'b10}], r.buff[{r.cm_idx, 2'b11}]};
			if (r.cm_idx == r.cm_last) begin
				n.cm_busy = 1'b0;
			end else begin
				n.cm_idx = r.cm_idx + 3'h1;
			end
		end
		n.slave_en = !i_master_mode;
		if (i_master_mode) begin
			// Master owns the bus; the slave lets go of both lines
			n.st = ST_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.bcnt = ISA_BCNT_RST;
		end else if (bus_start || bus_stop) begin
			// Any partly gathered set is thrown away
			n.bcnt = ISA_BCNT_RST;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.bitc = 4'h0;
			n.st = bus_start ? ST_ADDR : ST_IDLE;
		end else begin
			unique case (r.st)
				ST_IDLE: begin
					n.sda_oe = 1'b0;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						n.sr = {r.sr[6:0], sda_in};
						n.bitc = r.bitc + 4'h1;
					end else if (scl_fall && r.bitc == ISA_BIT_LAST) begin
						if (addr_hit(r.sr, lv[ISA_PIN_SEL_HI], lv[ISA_PIN_SEL_LO])) begin
							n.st = ST_AACK;
							n.sda_oe = 1'b1;
							n.rw = r.sr[0];
						end else begin
							n.st = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						n.bitc = 4'h0;
						n.sda_oe = 1'b0;
						if (r.rw) begin
							// Read starts at the assigned subaddress
							n.st = ST_FETCH;
							n.rword = 3'h0;
							n.rbyte = 2'h0;
							n.rd_req = 1'b1;
							n.scl_oe = 1'b1;
						end else begin
							n.st = ST_WR;
							n.first = 1'b1;
						end
					end
				end
				ST_WR: begin
					if (scl_rise) begin
						n.sr = {r.sr[6:0], sda_in};
						n.bitc = r.bitc + 4'h1;
					end else if (scl_fall && r.bitc == ISA_BIT_LAST) begin
						n.st = ST_WACK;
						n.sda_oe = 1'b1;
						if (r.first) begin
							// First byte of each write always replaces the subaddress
							n.sa = r.sr;
							n.first = 1'b0;
							n.bcnt = ISA_BCNT_RST;
						end else begin
							n.buff[r.bcnt[4:0]] = r.sr;
							if (r.bcnt + 6'h01 == setb) begin
								// Set complete: hand it on and step to the next subaddress
								n.bcnt = ISA_BCNT_RST;
								n.cm_busy = 1'b1;
								n.cm_idx = 3'h0;
								n.cm_last = 3'(setw - 4'h1);
								n.cm_sa = r.sa;
								n.sa = r.sa + 8'h01;
							end else begin
								n.bcnt = r.bcnt + 6'h01;
							end
						end
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						n.st = ST_WR;
						n.sda_oe = 1'b0;
						n.bitc = 4'h0;
					end
				end
				ST_FETCH: begin
					// SCL held low until the word arrives; later bytes need no wait
					if (r.rbyte != 2'h0 || i_rd_ack) begin
						n.rdw = word_sel;
						n.sr = byte_sel;
						n.sda_oe = !byte_sel[7];
						n.st = ST_LOAD;
					end
				end
				ST_LOAD: begin
					// One cycle of SDA setup before SCL is let go
					n.scl_oe = 1'b0;
					n.st = ST_RD;
				end
				ST_RD: begin
					if (scl_rise) begin
						n.bitc = r.bitc + 4'h1;
					end else if (scl_fall) begin
						if (r.bitc == ISA_BIT_LAST) begin
							n.sda_oe = 1'b0;
							n.st = ST_RACK;
						end else begin
							n.sr = {r.sr[6:0], 1'b0};
							n.sda_oe = !r.sr[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						n.hack = !sda_in;
					end else if (scl_fall) begin
						n.bitc = 4'h0;
						if (r.hack) begin
							n.st = ST_FETCH;
							n.scl_oe = 1'b1;
							if (r.rbyte == ISA_LAST_BYTE) begin
								n.rbyte = 2'h0;
								n.rd_req = 1'b1;
								if (r.rword == 3'(setw - 4'h1)) begin
									// Past the set: carry on at the next subaddress
									n.rword = 3'h0;
									n.sa = r.sa + 8'h01;
								end else begin
									n.rword = r.rword + 3'h1;
								end
							end else begin
								n.rbyte = r.rbyte + 2'h1;
							end
						end else begin
							// No acknowledge: stop sending, set may stay partly read
							n.st = ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.sa <= ISA_SUBADDR_RST;
		end else begin
			r <= n;
		end
	end

	// All outputs leave straight from the state register
	assign o_scl_o = r.lo;
	assign o_sda_o = r.lo;
	assign o_scl_oe = r.scl_oe;
	assign o_sda_oe = r.sda_oe;
	assign o_slave_en = r.slave_en;
	assign o_cur_subaddr = r.sa;
	assign o_wr_valid = r.wr_valid;
	assign o_wr_subaddr = r.wr_sa;
	assign o_wr_word_idx = r.wr_idx;
	assign o_wr_data = r.wr_data;
	assign o_rd_req = r.rd_req;
	assign o_rd_word_idx = r.rword;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	sequence byte_end_s;
		scl_fall && r.bitc == ISA_BIT_LAST && !bus_start && !bus_stop && !i_master_mode;
	endsequence
	sequence wr_byte_end_s;
		r.st == ST_WR ##0 byte_end_s;
	endsequence

	sda_only_low_a: assert property (($changed(o_sda_oe) && !$past(i_master_mode)
		&& !$past(bus_start) && !$past(bus_stop)) |-> !$past(lv[ISA_PIN_SCL]))
		else $error("SDA drive changed while SCL high");
	write_ack_a: assert property (wr_byte_end_s |=> o_sda_oe && r.st == ST_WACK)
		else $error("write byte not acknowledged");
	ack_hold_a: assert property (r.st == ST_WACK && !scl_fall && !bus_start && !bus_stop
		&& !i_master_mode |=> o_sda_oe)
		else $error("acknowledge released early");
	addr_match_a: assert property ((r.st == ST_ADDR ##0 byte_end_s) |=> (r.st == ST_AACK) ==
		($past(addr_hit(r.sr, lv[ISA_PIN_SEL_HI], lv[ISA_PIN_SEL_LO]))))
		else $error("address match decision wrong");
	no_match_a: assert property (r.st == ST_IDLE |-> ##1 !o_sda_oe [*2])
		else $error("SDA driven while not addressed");
	discard_a: assert property ((bus_start || bus_stop) |=> r.bcnt == ISA_BCNT_RST)
		else $error("partial set kept after bus condition");
	set_first_a: assert property ($rose(o_wr_valid) |-> o_wr_word_idx == 3'h0)
		else $error("set output did not begin at word 0");
	sa_advance_a: assert property ($rose(r.cm_busy) |-> o_cur_subaddr == r.cm_sa + 8'h01)
		else $error("subaddress did not advance after set");
	stretch_a: assert property ((r.st == ST_FETCH && r.rbyte == 2'h0 && !i_rd_ack
		&& !bus_start && !bus_stop && !i_master_mode) |-> o_scl_oe)
		else $error("SCL not held during wait state");
	release_a: assert property ((r.st == ST_FETCH && i_rd_ack && !bus_start && !bus_stop
		&& !i_master_mode) |-> ##[2:3] !o_scl_oe)
		else $error("SCL not released after data ready");
	zero_fill_a: assert property ((r.st == ST_FETCH && r.rbyte == 2'h0 && i_rd_ack)
		|=> (r.rdw & ~isa_mask($past(i_rd_bits))) == 32'h00000000)
		else $error("unused bits not zero");
	master_excl_a: assert property (i_master_mode |=> !o_slave_en && !o_sda_oe && !o_scl_oe)
		else $error("slave active with master enabled");

endmodule

/* File: dv/isa_host_model.sv */
// Bus host model: Start, Stop and byte clocks, waiting out clock stretches
`timescale 1ns/1ns
module isa_host_model (
	input wire logic i_sys_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_drv,
	output logic o_sda_drv
);
	// Both lines released at time zero; the pull-ups hold them high
	initial begin
		o_scl_drv = 1'b1;
		o_sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	// Releasing SCL need not raise it, since the device may hold it low
	task automatic scl_up();
		o_scl_drv = 1'b1;
		tick(1);
		while (i_scl !== 1'b1) begin
			tick(1);
		end
	endtask
	// SDA moves only in the low phase; the wire is sampled mid high phase
	task automatic clk_bit(input logic b, output logic r);
		tick(5);
		o_sda_drv = b;
		tick(15);
		scl_up();
		tick(10);
		r = i_sda;
		tick(10);
		o_scl_drv = 1'b0;
	endtask
	// Also serves as repeated Start when SCL is already low
	task automatic start();
		tick(5);
		o_sda_drv = 1'b1;
		tick(15);
		scl_up();
		tick(20);
		o_sda_drv = 1'b0;
		tick(20);
		o_scl_drv = 1'b0;
	endtask
	task automatic stop();
		tick(5);
		o_sda_drv = 1'b0;
		tick(15);
		scl_up();
		tick(20);
		o_sda_drv = 1'b1;
		tick(40);
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], r);
		end
		clk_bit(1'b1, r);
		ack = ~r;
	endtask
	// The caller acknowledges every byte except the last
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(~ack, r);
	endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench: host model on the bus, read responder, write monitor
`timescale 1ns/1ns
module testbench;
	import isa_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_master_mode = 1'b0;
	logic sel_lo = 1'b0;
	logic sel_hi = 1'b0;
	logic [3:0] set_w = 4'h2;
	logic rd_ack = 1'b0;
	logic [31:0] rd_data = 32'h0;
	logic [5:0] rd_bits = 6'h00;
	logic scl_oe, scl_o, sda_oe, sda_o, host_scl, host_sda, slave_en, wr_valid, rd_req;
	logic [7:0] cur_sa, wr_sa;
	logic [2:0] wr_idx, rd_idx;
	logic [31:0] wr_data, salt;
	logic [42:0] exp_q[$];
	logic [42:0] act_q[$];
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int rd_wait = 0;
	// Open-drain wires with pull-ups
	wire scl_w = host_scl & (scl_oe ? scl_o : 1'b1);
	wire sda_w = host_sda & (sda_oe ? sda_o : 1'b1);
	always #50 i_sys_clk = ~i_sys_clk;
	isa_slave dut (
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_scl(scl_w), .o_scl_o(scl_o),
		.o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.i_addr_select_low_pin(sel_lo), .i_addr_select_high_pin(sel_hi),
		.i_master_mode(i_master_mode), .o_slave_en(slave_en), .o_cur_subaddr(cur_sa),
		.i_set_words(set_w), .o_wr_valid(wr_valid), .o_wr_subaddr(wr_sa),
		.o_wr_word_idx(wr_idx), .o_wr_data(wr_data), .o_rd_req(rd_req),
		.o_rd_word_idx(rd_idx), .i_rd_ack(rd_ack), .i_rd_data(rd_data), .i_rd_bits(rd_bits)
	);
	isa_host_model host (
		.i_sys_clk(i_sys_clk), .i_scl(scl_w), .i_sda(sda_w),
		.o_scl_drv(host_scl), .o_sda_drv(host_sda)
	);
	function automatic logic [31:0] word_of(input logic [7:0] sa, input logic [2:0] ix);
		return {sa, 5'h00, ix, ~sa, sa ^ 8'h5A} ^ salt;
	endfunction
	function automatic logic [6:0] dev_addr();
		return {ISA_ADDR_PREFIX, sel_hi, sel_lo};
	endfunction
	// Read port answers after a random delay, so stretches vary in length
	always @(negedge i_sys_clk) begin
		rd_ack <= 1'b0;
		if (rd_wait > 0) begin
			rd_wait--;
			if (rd_wait == 0) begin
				rd_ack <= 1'b1;
				rd_data <= word_of(cur_sa, rd_idx);
			end
		end else if (rd_req === 1'b1) begin
			rd_wait = 1 + $urandom_range(0, 60);
		end
	end
	// Collect written words; cut a hang short
	always @(posedge i_sys_clk) begin
		cyc++;
		if (wr_valid === 1'b1) begin
			act_q.push_back({wr_sa, wr_idx, wr_data});
		end
		if (cyc == 90000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk_bit(input logic a, input logic e);
		checks++;
		if (a !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, a, e);
		end
	endtask
	task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
		checks++;
		if (a !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, a, e);
		end
	endtask
	task automatic chk_wr(input logic [42:0] a, input logic [42:0] e);
		checks++;
		if (a !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, a, e);
		end
	endtask
	// Address, subaddress, nb random bytes; only complete sets are expected out
	task automatic wr_xfer(input logic [6:0] a, input logic [7:0] sa,
			input int nb, input logic ea);
		logic k;
		logic [31:0] w;
		int spb;
		spb = 4 * int'(set_w);
		host.start();
		host.wr_byte({a, 1'b0}, k);
		chk_bit(k, ea);
		if (ea) begin
			host.wr_byte(sa, k);
			chk_bit(k, 1'b1);
			for (int i = 0; i < nb; i++) begin
				w = {w[23:0], 8'($urandom)};
				host.wr_byte(w[7:0], k);
				chk_bit(k, 1'b1);
				if (i % 4 == 3 && i < nb / spb * spb) begin
					exp_q.push_back({sa + 8'(i / spb), 3'((i / 4) % int'(set_w)), w});
				end
			end
		end
	endtask
	task automatic chk_writes(input string name);
		host.tick(10);
		chk_wr(43'(act_q.size()), 43'(exp_q.size()));
		while (act_q.size() > 0 && exp_q.size() > 0) begin
			chk_wr(act_q.pop_front(), exp_q.pop_front());
		end
		act_q.delete();
		exp_q.delete();
		$display("test %s done", name);
	endtask
	// Subaddress write, then a read of nb bytes, the last one not acknowledged
	task automatic rd_xfer(input logic [7:0] sa, input int nb);
		logic k;
		logic [7:0] d, s;
		logic [31:0] m, w;
		int ix, bi;
		wr_xfer(dev_addr(), sa, 0, 1'b1);
		host.stop();
		rd_bits = 6'($urandom);
		m = (rd_bits == 6'h00 || rd_bits >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << rd_bits) - 32'h1;
		host.start();
		host.wr_byte({dev_addr(), 1'b1}, k);
		chk_bit(k, 1'b1);
		s = sa;
		ix = 0;
		bi = 0;
		for (int i = 0; i < nb; i++) begin
			host.rd_byte(i != nb - 1, d);
			w = word_of(s, 3'(ix)) & m;
			chk_byte(d, w[31 - 8 * bi -: 8]);
			bi = (bi + 1) % 4;
			ix = (bi == 0) ? ix + 1 : ix;
			if (ix == int'(set_w)) begin
				ix = 0;
				s++;
			end
		end
		host.stop();
		$display("test read %0d bytes done", nb);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		salt = $urandom(32'h3c7dfc14);
		host.tick(16);
		i_resetn = 1'b1;
		host.tick(8);
		chk_bit(slave_en, 1'b1);
		// Random set size; whole sets kept, the tail dropped
		set_w = 4'h1 + 4'($urandom_range(0, 2));
		wr_xfer(dev_addr(), 8'h3E, 19, 1'b1);
		host.stop();
		chk_writes("sequential write");
		set_w = 4'h2;
		// Subaddress alone, a partial set cut by repeated Start, then a full set
		wr_xfer(dev_addr(), 8'h10, 0, 1'b1);
		host.stop();
		wr_xfer(dev_addr(), 8'h20, 5, 1'b1);
		wr_xfer(dev_addr(), 8'h30, 8, 1'b1);
		host.stop();
		chk_writes("override");
		set_w = 4'h1;
		wr_xfer(7'h00, 8'hFE, 4, 1'b1);
		host.stop();
		chk_writes("broadcast");
		// Every select pin setting, each with two near-miss addresses
		for (int p = 0; p < 4; p++) begin
			{sel_hi, sel_lo} = 2'(p);
			host.tick(4);
			wr_xfer(dev_addr(), 8'h40, 4, 1'b1);
			host.stop();
			wr_xfer(dev_addr() ^ 7'h01, 8'h41, 4, 1'b0);
			host.stop();
			wr_xfer(dev_addr() ^ 7'h02, 8'h42, 4, 1'b0);
			host.stop();
		end
		chk_writes("select pins");
		set_w = 4'h3;
		rd_xfer(8'h52, 15);
		set_w = 4'h2;
		rd_xfer(8'h07, 6);
		// Master function on: the slave must stay silent
		i_master_mode = 1'b1;
		host.tick(2);
		chk_bit(slave_en, 1'b0);
		wr_xfer(dev_addr(), 8'h01, 0, 1'b0);
		host.stop();
		i_master_mode = 1'b0;
		host.tick(2);
		chk_bit(slave_en, 1'b1);
		chk_writes("master mode");
		tally_and_finish();
	end
endmodule
